// ===== inc/pwr_seq_defines.svh
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH

// Register byte offsets
`define A_CTRL 5'h00
`define A_STAT 5'h04
`define A_WAKE_EN 5'h08
`define A_WHEEL 5'h0c
`define A_VSEL 5'h10
`define A_ISTS 5'h14
`define A_IMASK 5'h18
`define A_REFRESH 5'h1c

// Event bit positions in status and mask; the first NUM_WAKE also in wake enable
`define EV_PIN 0
`define EV_PERIPH 1
`define EV_SUPV 2
`define EV_WHEEL 3
`define EV_RESET 4
`define EV_REFRESH 5
`define NUM_WAKE 4
`define NUM_EV 6

// Timing
`define CLK_KHZ 100000
`define BOOST_KHZ 400
`define BOOST_DIV (`CLK_KHZ / `BOOST_KHZ)
`define RESUME_MAX_US 100
`define RESUME_MAX_CYC (`RESUME_MAX_US * `CLK_KHZ / 1000)
`define RESUME_CYC 16'h0010
`define BOOT_CYC 16'h0010
`define SETTLE_CYC 16'h0004
`define REFRESH_CYC 16'h0008

// Reset values and limits
`define WHEEL_RST 16'h03e8
`define REFRESH_RST 16'h2710
`define VSEL_MAX 6'h20
`define VSEL_RST 6'h0f

`endif

// ===== inc/pwr_seq_pkg.sv
package pwr_seq_pkg;

   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'b00,
      MODE_ALT = 2'b01,
      MODE_SLEEP = 2'b10,
      MODE_HIB = 2'b11
   } chip_mode_t;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_ACT = 3'b001,
      ST_ENTER = 3'b010,
      ST_SLEEP = 3'b011,
      ST_HIB = 3'b100,
      ST_REFRESH = 3'b101,
      ST_WAKE = 3'b110
   } seq_state_t;

   // Control register, bits 3:0
   typedef struct packed {
      logic cpu_en;
      logic boost_sby;
      chip_mode_t mode;
   } ctrl_t;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [4:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avm_req_t;

endpackage

// ===== rtl/pwr_seq.sv
// What this block does
// - Hibernate disables nearly all functions, keeps configuration and memory intact.
// - In hibernate digital outputs hold level; pin interrupt setup unchanged.
// - Only an external pin interrupt ends hibernate.
// - Return from hibernate completes in under 100 us.
// - Every wake event returns the chip to the main active mode.
// - Peripheral, supervisor, wheel timer and pin interrupts wake, each enabled.
// - Periodic wheel timer raises repeating interrupts that can wake the chip.
// - Reset pin, watchdog expiry and precise low-voltage reset are wake events.
// - Boost voltage code steps 100 mV from 1.8 V to 5.0 V.
// - Boost switches at 400 kHz from its own divider, not the clock tree.
// - Boost has only two modes: active and standby.
// - Chip active or alternate active forces boost active.
// - Sleep with boost standby wakes periodically for a boost refresh.
// - Hibernate may keep boost active; standby is never used there.
// - Fast startup option off runs startup at 12 MHz, else 48 MHz.
// - After boot the chip mode is main active.
// - Any wake other than a boost refresh re-enables the processor regardless of its template bit.
`include "pwr_seq_defines.svh"

module pwr_seq
   import pwr_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic pin_irq,
   input wire logic periph_irq,
   input wire logic supervisor_irq,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_expiry,
   input wire logic precise_low_voltage_reset,
   input wire logic fast_startup_strap,
   output chip_mode_t chip_mode,
   output logic cpu_en,
   output logic io_hold,
   output logic func_off,
   output logic boost_standby,
   output logic boost_tick,
   output logic [5:0] boost_vsel,
   output logic clk_48m_sel,
   output logic wheel_irq,
   output logic irq
);

   typedef struct packed {
      seq_state_t fsm;
      logic [15:0] cnt;
      logic [15:0] wheel_cnt;
      logic [15:0] ref_cnt;
      logic [7:0] bdiv;
      ctrl_t ctrl;
      logic hib_target;
      logic [`NUM_WAKE-1:0] wake_en;
      logic [15:0] wheel_per;
      logic [15:0] ref_per;
      logic [5:0] vsel;
      logic [`NUM_EV-1:0] ists;
      logic [`NUM_EV-1:0] imask;
      chip_mode_t mode;
      logic boost_sby;
      logic cpu_en;
      logic hold;
      logic startup_fast;
      logic fast_clk;
      logic boost_tick;
      logic wheel_irq;
      logic irq;
      logic wait_r;
      logic [31:0] rdata;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   avm_req_t req;
   assign req = '{address, read, write, writedata, byteenable};

   // Byte-lane merge of a write into an old register value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            m[i*8 +: 8] = wd[i*8 +: 8];
      end
      return m;
   endfunction

   logic [`NUM_EV-1:0] ev;
   logic rst_ev;
   logic wake_req;
   logic acc;
   logic wr_acc;
   logic [`NUM_EV-1:0] w1c;
   logic [31:0] mv;

   // Next-state logic for the whole block
   always_comb
   begin
      s_nxt = s_r;
      ev = '0;
      mv = 32'h0000_0000;
      s_nxt.boost_tick = 1'b0;
      s_nxt.wheel_irq = 1'b0;

      // Boost switching enable, from its own divider only
      if (s_r.bdiv == 8'(`BOOST_DIV - 1))
      begin
         s_nxt.bdiv = 8'h00;
         s_nxt.boost_tick = 1'b1;
      end
      else
         s_nxt.bdiv = s_r.bdiv + 8'h01;

      // Wheel timer; stopped in hibernate as no clocks run there
      if (s_r.fsm != ST_HIB)
      begin
         if (s_r.wheel_cnt >= s_r.wheel_per)
         begin
            s_nxt.wheel_cnt = 16'h0000;
            s_nxt.wheel_irq = 1'b1;
            ev[`EV_WHEEL] = 1'b1;
         end
         else
            s_nxt.wheel_cnt = s_r.wheel_cnt + 16'h0001;
      end

      // Wake sources
      ev[`EV_PIN] = pin_irq;
      ev[`EV_PERIPH] = periph_irq;
      ev[`EV_SUPV] = supervisor_irq;
      rst_ev = !external_reset_pin_n || watchdog_expiry
               || precise_low_voltage_reset;
      ev[`EV_RESET] = rst_ev;
      wake_req = (|(ev[`NUM_WAKE-1:0] & s_r.wake_en)) || rst_ev;

      // Sequencer
      case (s_r.fsm)
         ST_BOOT:
         begin
            s_nxt.mode = MODE_ACTIVE;
            s_nxt.fast_clk = s_r.startup_fast;
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt >= `BOOT_CYC)
            begin
               s_nxt.fsm = ST_ACT;
               s_nxt.mode = MODE_ACTIVE;
               s_nxt.fast_clk = 1'b1;
               s_nxt.cnt = 16'h0000;
            end
         end
         ST_ACT:
         begin
            s_nxt.boost_sby = 1'b0;
            s_nxt.cpu_en = s_r.ctrl.cpu_en;
            s_nxt.cnt = 16'h0000;
            if (s_r.ctrl.mode == MODE_SLEEP || s_r.ctrl.mode == MODE_HIB)
            begin
               // Boost stays active until the chip has really left active mode
               s_nxt.fsm = ST_ENTER;
               s_nxt.hib_target = (s_r.ctrl.mode == MODE_HIB);
            end
            else
               s_nxt.mode = s_r.ctrl.mode;
         end
         ST_ENTER:
         begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (wake_req && !s_r.hib_target)
            begin
               s_nxt.fsm = ST_WAKE;
               s_nxt.boost_sby = 1'b0;
               s_nxt.cnt = 16'h0000;
            end
            else if (s_r.cnt >= `SETTLE_CYC)
            begin
               s_nxt.cnt = 16'h0000;
               s_nxt.cpu_en = 1'b0;
               s_nxt.ref_cnt = 16'h0000;
               s_nxt.ctrl.mode = MODE_ACTIVE;
               if (s_r.hib_target)
               begin
                  s_nxt.fsm = ST_HIB;
                  s_nxt.mode = MODE_HIB;
                  s_nxt.hold = 1'b1;
                  s_nxt.boost_sby = 1'b0;
               end
               else
               begin
                  s_nxt.fsm = ST_SLEEP;
                  s_nxt.mode = MODE_SLEEP;
                  s_nxt.boost_sby = s_r.ctrl.boost_sby;
               end
            end
         end
         ST_SLEEP:
         begin
            if (wake_req)
            begin
               s_nxt.fsm = ST_WAKE;
               s_nxt.boost_sby = 1'b0;
               s_nxt.cnt = 16'h0000;
            end
            else if (s_r.boost_sby)
            begin
               s_nxt.ref_cnt = s_r.ref_cnt + 16'h0001;
               if (s_r.ref_cnt >= s_r.ref_per)
               begin
                  s_nxt.fsm = ST_REFRESH;
                  s_nxt.boost_sby = 1'b0;
                  s_nxt.ref_cnt = 16'h0000;
                  s_nxt.cnt = 16'h0000;
                  ev[`EV_REFRESH] = 1'b1;
               end
            end
         end
         ST_REFRESH:
         begin
            // Brief active wake with the processor left off
            s_nxt.mode = MODE_ACTIVE;
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (wake_req)
            begin
               s_nxt.fsm = ST_WAKE;
               s_nxt.cnt = 16'h0000;
            end
            else if (s_r.cnt >= `REFRESH_CYC)
            begin
               s_nxt.fsm = ST_SLEEP;
               s_nxt.mode = MODE_SLEEP;
               s_nxt.boost_sby = 1'b1;
               s_nxt.cnt = 16'h0000;
            end
         end
         ST_HIB:
         begin
            // Internal sources and resets are ignored here
            if (pin_irq)
            begin
               s_nxt.fsm = ST_WAKE;
               s_nxt.cnt = 16'h0000;
            end
         end
         ST_WAKE:
         begin
            s_nxt.boost_sby = 1'b0;
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_r.cnt >= `RESUME_CYC)
            begin
               s_nxt.fsm = ST_ACT;
               s_nxt.mode = MODE_ACTIVE;
               s_nxt.cpu_en = 1'b1;
               s_nxt.ctrl.cpu_en = 1'b1;
               s_nxt.hold = 1'b0;
               s_nxt.cnt = 16'h0000;
            end
         end
         default:
         begin
            s_nxt.fsm = ST_ACT;
            s_nxt.mode = MODE_ACTIVE;
         end
      endcase

      // Bus slave: one wait cycle; reads captured on taking, writes land on completion
      acc = (req.read || req.write) && s_r.wait_r;
      wr_acc = req.write && !s_r.wait_r && (s_r.fsm != ST_HIB);
      s_nxt.wait_r = !acc;
      w1c = '0;
      if (acc && req.read)
      begin
         case (req.address)
            `A_CTRL: s_nxt.rdata = {28'h0, s_r.ctrl};
            `A_STAT: s_nxt.rdata = {23'h0, s_r.fsm, s_r.fast_clk, s_r.hold,
                                     s_r.cpu_en, s_r.boost_sby, s_r.mode};
            `A_WAKE_EN: s_nxt.rdata = {28'h0, s_r.wake_en};
            `A_WHEEL: s_nxt.rdata = {16'h0, s_r.wheel_per};
            `A_VSEL: s_nxt.rdata = {26'h0, s_r.vsel};
            `A_ISTS: s_nxt.rdata = {26'h0, s_r.ists};
            `A_IMASK: s_nxt.rdata = {26'h0, s_r.imask};
            `A_REFRESH: s_nxt.rdata = {16'h0, s_r.ref_per};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc)
      begin
         case (req.address)
            `A_CTRL:
            begin
               mv = merge({28'h0, s_r.ctrl}, req.writedata, req.byteenable);
               s_nxt.ctrl = ctrl_t'(mv[3:0]);
            end
            `A_WAKE_EN:
            begin
               mv = merge({28'h0, s_r.wake_en}, req.writedata, req.byteenable);
               s_nxt.wake_en = mv[`NUM_WAKE-1:0];
            end
            `A_WHEEL:
            begin
               mv = merge({16'h0, s_r.wheel_per}, req.writedata, req.byteenable);
               s_nxt.wheel_per = mv[15:0];
            end
            `A_VSEL:
            begin
               mv = merge({26'h0, s_r.vsel}, req.writedata, req.byteenable);
               // Codes past the top step clamp to 5.0 V
               if (mv[5:0] > `VSEL_MAX)
                  s_nxt.vsel = `VSEL_MAX;
               else
                  s_nxt.vsel = mv[5:0];
            end
            `A_ISTS:
            begin
               if (req.byteenable[0])
                  w1c = req.writedata[`NUM_EV-1:0];
            end
            `A_IMASK:
            begin
               mv = merge({26'h0, s_r.imask}, req.writedata, req.byteenable);
               s_nxt.imask = mv[`NUM_EV-1:0];
            end
            `A_REFRESH:
            begin
               mv = merge({16'h0, s_r.ref_per}, req.writedata, req.byteenable);
               s_nxt.ref_per = mv[15:0];
            end
            default: ;
         endcase
      end

      // Sticky status; a new event wins over a clear in the same cycle
      for (int i = 0; i < `NUM_EV; i++)
      begin
         s_nxt.ists[i] = ev[i] || (s_r.ists[i] && !w1c[i]);
      end
      s_nxt.irq = |(s_nxt.ists & s_nxt.imask);

      // Synchronous reset; strap is caught while reset is held
      if (reset)
      begin
         s_nxt = '0;
         s_nxt.fsm = ST_BOOT;
         s_nxt.mode = MODE_ACTIVE;
         s_nxt.ctrl.mode = MODE_ACTIVE;
         s_nxt.ctrl.cpu_en = 1'b1;
         s_nxt.cpu_en = 1'b1;
         s_nxt.wheel_per = `WHEEL_RST;
         s_nxt.ref_per = `REFRESH_RST;
         s_nxt.vsel = `VSEL_RST;
         s_nxt.wait_r = 1'b1;
         s_nxt.startup_fast = fast_startup_strap;
      end
   end

   // State register
   always_ff @(posedge ref_clk)
   begin
      s_r <= s_nxt;
   end

   // Outputs straight from the state register
   assign readdata = s_r.rdata;
   assign waitrequest = s_r.wait_r;
   assign chip_mode = s_r.mode;
   assign cpu_en = s_r.cpu_en;
   assign io_hold = s_r.hold;
   assign func_off = s_r.hold;
   assign boost_standby = s_r.boost_sby;
   assign boost_tick = s_r.boost_tick;
   assign boost_vsel = s_r.vsel;
   assign clk_48m_sel = s_r.fast_clk;
   assign wheel_irq = s_r.wheel_irq;
   assign irq = s_r.irq;

endmodule

// ===== bench/pwr_seq_chk.sv
module pwr_seq_chk
   import pwr_seq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic pin_irq,
   input chip_mode_t chip_mode,
   input wire logic cpu_en,
   input wire logic io_hold,
   input wire logic func_off,
   input wire logic boost_standby,
   input wire logic boost_tick,
   input wire logic [5:0] boost_vsel,
   input wire logic clk_48m_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_hib_r;
   logic pin_seen_r;
   logic tick_seen_r;
   logic [8:0] tick_cnt_r;

   // Remember a pin event inside hibernate; any other exit is illegal
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         prev_hib_r <= 1'b0;
         pin_seen_r <= 1'b0;
         tick_seen_r <= 1'b0;
         tick_cnt_r <= 9'h000;
      end
      else
      begin
         prev_hib_r <= (chip_mode == MODE_HIB);
         pin_seen_r <= (chip_mode == MODE_HIB) && (pin_irq || pin_seen_r);
         tick_seen_r <= tick_seen_r || boost_tick;
         tick_cnt_r <= boost_tick ? 9'h000 : tick_cnt_r + 9'h001;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered in one cycle");
   bus_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   func_off_a: assert property (func_off |-> chip_mode == MODE_HIB)
      else $error("functions off outside hibernate");
   io_hold_a: assert property (io_hold |-> chip_mode == MODE_HIB)
      else $error("pin hold outside hibernate");
   hib_exit_pin_a: assert property (prev_hib_r && chip_mode != MODE_HIB |-> pin_seen_r)
      else $error("hibernate left without a pin event");
   hib_resume_a: assert property (
      $rose(pin_irq) && chip_mode == MODE_HIB |-> ##[1:40] chip_mode == MODE_ACTIVE)
      else $error("resume from hibernate too slow");
   hib_cpu_a: assert property (
      chip_mode == MODE_ACTIVE && $past(chip_mode) == MODE_HIB |-> cpu_en)
      else $error("processor not enabled on wake");
   boost_act_a: assert property (
      chip_mode inside {MODE_ACTIVE, MODE_ALT} |-> !boost_standby)
      else $error("boost in standby while chip active");
   tick_period_a: assert property (boost_tick && tick_seen_r |-> tick_cnt_r == 9'h0f9)
      else $error("boost tick period wrong");
   vsel_max_a: assert property (boost_vsel <= 6'h20)
      else $error("boost voltage code out of range");
   clk_fast_a: assert property (chip_mode != MODE_ACTIVE |-> clk_48m_sel)
      else $error("startup clock still selected");

   cover property (prev_hib_r && chip_mode == MODE_ACTIVE);
   cover property (chip_mode == MODE_SLEEP && boost_standby);
   cover property ($fell(boost_standby) && chip_mode == MODE_SLEEP);
endmodule

// ===== bench/testbench.sv
`include "pwr_seq_defines.svh"

module testbench
   import pwr_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, read, write, pin_irq, periph_irq, supervisor_irq;
   logic external_reset_pin_n, watchdog_expiry, precise_low_voltage_reset, fast_startup_strap;
   logic waitrequest, cpu_en, io_hold, func_off, boost_standby, boost_tick;
   logic clk_48m_sel, wheel_irq, irq;
   logic [4:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, rd;
   logic [5:0] boost_vsel;
   chip_mode_t chip_mode;
   int failures, samples_checked, cyc;

   pwr_seq pwr_seq_inst (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .pin_irq(pin_irq), .periph_irq(periph_irq),
      .supervisor_irq(supervisor_irq), .external_reset_pin_n(external_reset_pin_n),
      .watchdog_expiry(watchdog_expiry), .precise_low_voltage_reset(precise_low_voltage_reset),
      .fast_startup_strap(fast_startup_strap), .chip_mode(chip_mode), .cpu_en(cpu_en),
      .io_hold(io_hold), .func_off(func_off), .boost_standby(boost_standby),
      .boost_tick(boost_tick), .boost_vsel(boost_vsel), .clk_48m_sel(clk_48m_sel),
      .wheel_irq(wheel_irq), .irq(irq));

   always #5 ref_clk = ~ref_clk;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Request held until the edge that sees waitrequest low
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      n = 0;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge ref_clk);
         n++;
      end
      rd = readdata;
      check(32'(n < 20), 32'h1);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task wait_mode(input chip_mode_t m, input int lim);
      int n;
      n = 0;
      while (chip_mode !== m && n < lim)
      begin
         @(posedge ref_clk);
         n++;
      end
      check(chip_mode, m);
   endtask

   // One-cycle event: 0 pin, 1 periph, 2 supervisor, 3 reset pin, 4 watchdog, 5 low volt
   task pulse(input int s);
      case (s)
         0: pin_irq <= 1'b1;
         1: periph_irq <= 1'b1;
         2: supervisor_irq <= 1'b1;
         3: external_reset_pin_n <= 1'b0;
         4: watchdog_expiry <= 1'b1;
         default: precise_low_voltage_reset <= 1'b1;
      endcase
      @(posedge ref_clk);
      {pin_irq, periph_irq, supervisor_irq} <= 3'h0;
      {watchdog_expiry, precise_low_voltage_reset} <= 2'h0;
      external_reset_pin_n <= 1'b1;
      @(posedge ref_clk);
   endtask

   task t_boot();
      idle(2);
      check(clk_48m_sel, 32'h0);
      check(chip_mode, MODE_ACTIVE);
      check(boost_vsel, 32'h0f);
      idle(20);
      check(clk_48m_sel, 32'h1);
      bus(1'b0, `A_WHEEL, 32'h0);
      check(rd, 32'h3e8);
      bus(1'b0, `A_CTRL, 32'h0);
      check(rd, 32'h8);
   endtask

   // Second reset as the last test, fast startup strap set this time
   task t_strap();
      reset <= 1'b1;
      fast_startup_strap <= 1'b1;
      idle(3);
      reset <= 1'b0;
      fast_startup_strap <= 1'b0;
      idle(2);
      check(clk_48m_sel, 32'h1);
      check(chip_mode, MODE_ACTIVE);
      check(cpu_en, 32'h1);
      idle(20);
      bus(1'b0, `A_WAKE_EN, 32'h0);
      check(rd, 32'h0);
   endtask

   // Codes above the top step clamp to 5.0 V
   task t_vsel();
      logic [31:0] w [3] = '{32'h21, 32'h0, 32'h20};
      logic [31:0] e;
      foreach (w[i])
      begin
         bus(1'b1, `A_VSEL, w[i]);
         bus(1'b0, `A_VSEL, 32'h0);
         e = (w[i] > 32'h20) ? 32'h20 : w[i];
         check(rd, e);
         check(boost_vsel, e);
      end
   endtask

   task t_irq();
      bus(1'b1, `A_IMASK, 32'h2);
      pulse(1);
      idle(2);
      check(irq, 32'h1);
      bus(1'b1, `A_ISTS, 32'h2);
      idle(1);
      check(irq, 32'h0);
      bus(1'b1, `A_IMASK, 32'h0);
      pulse(1);
      idle(2);
      check(irq, 32'h0);
      bus(1'b1, `A_ISTS, 32'h3f);
   endtask

   task t_sleep();
      bus(1'b1, `A_WAKE_EN, 32'h2);
      bus(1'b1, `A_CTRL, 32'h6);
      wait_mode(MODE_SLEEP, 10);
      check(boost_standby, 32'h1);
      check(cpu_en, 32'h0);
      pulse(2);
      idle(30);
      check(chip_mode, MODE_SLEEP);
      pulse(1);
      idle(2);
      check(boost_standby, 32'h0);
      wait_mode(MODE_ACTIVE, 30);
      check(cpu_en, 32'h1);
      bus(1'b0, `A_ISTS, 32'h0);
      check(rd & 32'h6, 32'h6);
      bus(1'b1, `A_ISTS, 32'h3f);
   endtask

   // Only the pin may end hibernate; writes there are dropped
   task t_hib();
      bus(1'b1, `A_WAKE_EN, 32'hf);
      bus(1'b1, `A_CTRL, 32'hb);
      wait_mode(MODE_HIB, 10);
      check(io_hold, 32'h1);
      check(func_off, 32'h1);
      check(boost_standby, 32'h0);
      bus(1'b1, `A_VSEL, 32'h5);
      for (int s = 1; s < 5; s++)
         pulse(s);
      idle(30);
      check(chip_mode, MODE_HIB);
      // One slow pin edge only, well under the toggle limit in hibernate
      pulse(0);
      wait_mode(MODE_ACTIVE, 40);
      check(io_hold, 32'h0);
      bus(1'b0, `A_VSEL, 32'h0);
      check(rd, 32'h20);
   endtask

   task t_reset_wake();
      bus(1'b1, `A_WAKE_EN, 32'h0);
      for (int s = 3; s < 6; s++)
      begin
         bus(1'b1, `A_CTRL, 32'ha);
         wait_mode(MODE_SLEEP, 10);
         pulse(s);
         wait_mode(MODE_ACTIVE, 40);
      end
   endtask

   task t_refresh();
      bus(1'b1, `A_REFRESH, 32'h20);
      bus(1'b1, `A_WAKE_EN, 32'h1);
      bus(1'b1, `A_CTRL, 32'h6);
      wait_mode(MODE_SLEEP, 10);
      wait_mode(MODE_ACTIVE, 60);
      check(boost_standby, 32'h0);
      wait_mode(MODE_SLEEP, 20);
      check(boost_standby, 32'h1);
      bus(1'b0, `A_ISTS, 32'h0);
      check(rd[5], 32'h1);
      pulse(0);
      wait_mode(MODE_ACTIVE, 40);
   endtask

   task t_wheel();
      int n;
      bus(1'b1, `A_WHEEL, 32'hf);
      idle(20);
      n = 0;
      repeat (64)
      begin
         @(posedge ref_clk);
         if (wheel_irq === 1'b1)
            n++;
      end
      check(n, 32'h4);
      // Wheel wake enabled only once asleep, so entry is not cut short
      bus(1'b1, `A_CTRL, 32'ha);
      wait_mode(MODE_SLEEP, 10);
      bus(1'b1, `A_WAKE_EN, 32'h8);
      wait_mode(MODE_ACTIVE, 50);
   endtask

   // A hang ends the run as a failure
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         give_verdict();
      end
   end

   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      {read, write, pin_irq, periph_irq, supervisor_irq} = 5'h00;
      {watchdog_expiry, precise_low_voltage_reset, fast_startup_strap} = 3'h0;
      external_reset_pin_n = 1'b1;
      address = 5'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_boot();
      t_vsel();
      t_irq();
      t_sleep();
      t_hib();
      t_reset_wake();
      t_refresh();
      t_wheel();
      t_strap();
      give_verdict();
   end
endmodule

bind pwr_seq pwr_seq_chk pwr_seq_chk_inst (.ref_clk(ref_clk), .reset(reset), .read(read),
   .write(write), .waitrequest(waitrequest), .pin_irq(pin_irq), .chip_mode(chip_mode),
   .cpu_en(cpu_en), .io_hold(io_hold), .func_off(func_off), .boost_standby(boost_standby),
   .boost_tick(boost_tick), .boost_vsel(boost_vsel), .clk_48m_sel(clk_48m_sel));
